//--- common/swdt_pkg.sv
/*
  swdt_pkg: register map, field layout, reset values and timing constants
  of the system watchdog timer.
  Assumes a 125 MHz system clock and a 32-bit APB register port.
*/
package swdt_pkg;

  // ----------------------------------------------------------------------
  // clock and one-second tick
  // ----------------------------------------------------------------------
  localparam int unsigned SWDT_CLK_HZ = 125000000;
  localparam int unsigned SWDT_TICK_S = 1;
  localparam int unsigned SWDT_TICK_CYC = SWDT_CLK_HZ * SWDT_TICK_S;
  localparam int unsigned SWDT_PRESC_W = 27;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] SWDT_OFF_CTRL = 8'h00;
  localparam logic [7:0] SWDT_OFF_TIMEOUT = 8'h04;
  localparam logic [7:0] SWDT_OFF_KICK = 8'h08;
  localparam logic [7:0] SWDT_OFF_COUNT = 8'h0c;
  localparam logic [7:0] SWDT_OFF_STATUS = 8'h10;
  localparam logic [7:0] SWDT_OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] SWDT_OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] SWDT_OFF_BOOT = 8'h1c;

  // ----------------------------------------------------------------------
  // field values
  // ----------------------------------------------------------------------
  localparam logic [1:0] SWDT_CTRL_OFF = 2'h0;
  localparam logic [1:0] SWDT_CTRL_ON = 2'h1;
  localparam logic [7:0] SWDT_TIMEOUT_RST = 8'hff;
  localparam logic [31:0] SWDT_KICK_KEY = 32'h0000_00c3;

  // boot supervision select codes and their timeouts in seconds
  localparam logic [1:0] SWDT_BOOT_NONE = 2'h0;
  localparam logic [1:0] SWDT_BOOT_30 = 2'h1;
  localparam logic [1:0] SWDT_BOOT_60 = 2'h2;
  localparam logic [1:0] SWDT_BOOT_90 = 2'h3;
  localparam logic [7:0] SWDT_BOOT_30_S = 8'd30;
  localparam logic [7:0] SWDT_BOOT_60_S = 8'd60;
  localparam logic [7:0] SWDT_BOOT_90_S = 8'd90;

  // status / interrupt bit positions
  localparam int unsigned SWDT_EV_EXPIRE = 0;
  localparam int unsigned SWDT_EV_KICK = 1;
  localparam int unsigned SWDT_EV_W = 2;

  // response state
  typedef enum logic [1:0] {
    SWDT_ST_IDLE = 2'b00,
    SWDT_ST_RUN = 2'b01,
    SWDT_ST_FIRED = 2'b11
  } swdt_state_t;

endpackage

//--- hdl/swdt_tick.sv
/*
  swdt_tick: free-running prescaler giving a one-cycle pulse once per second.
  Assumes sys_clk at the rate named in swdt_pkg; restart aligns the second.
*/
`timescale 1ns/100ps
module swdt_tick
  import swdt_pkg::*;
#(
  parameter int unsigned TICK_CYC = SWDT_TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // control
  input wire logic restart,
  output logic tick
);

  logic [SWDT_PRESC_W-1:0] cnt_ff;
  logic tick_ff;

  // restarting on reload makes every timeout a full whole number of seconds
  always_ff @(posedge sys_clk) begin
    if (!nrst || restart) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == SWDT_PRESC_W'(TICK_CYC - 1)) begin
      cnt_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  assign tick = tick_ff;

endmodule

//--- hdl/swdt_top.sv
/*
  swdt_top: system watchdog timer with APB register port and interrupt.
  Assumes a single 125 MHz clock, synchronous active-low reset, a static
  boot select and response jumper, and an external reset/alert circuit
  that consumes the expiry outputs.
*/
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps

// How it works
// - A boot select leaves the watchdog idle after reset or arms it for 30, 60 or 90 seconds.
// - Software may stop the countdown at any time through registers, start it from idle, and retrigger it while it runs.
// - On expiry the block raises the response that the board jumper selects.
// - A control value of 00 disables the watchdog and 01 enables it.
// - An 8-bit timeout register gives the period directly in whole seconds, 1 to 255.
module swdt_top
  import swdt_pkg::*;
#(
  parameter int unsigned TICK_CYC = SWDT_TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // board straps
  input wire logic [1:0] boot_sel,
  input wire logic resp_sel,
  // expiry response and interrupt
  output logic sys_reset_req,
  output logic nmi_req,
  output logic irq
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  swdt_state_t state_ff, nxt_state;
  logic [1:0] ctrl_ff;
  logic [7:0] timeout_ff;
  logic [7:0] count_ff;
  logic [SWDT_EV_W-1:0] status_ff;
  logic [SWDT_EV_W-1:0] irq_en_ff;
  logic [1:0] boot_ff;
  logic boot_done_ff;
  logic boot_pend_ff;
  logic rst_req_ff;
  logic nmi_req_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  logic wr_acc, rd_acc, addr_ok;
  logic wr_ctrl, wr_timeout, wr_kick, wr_clr, wr_en;
  logic boot_arm, reload, tick, expire;
  logic [7:0] boot_to;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  always_comb begin
    case (paddr)
      SWDT_OFF_CTRL, SWDT_OFF_TIMEOUT, SWDT_OFF_KICK, SWDT_OFF_COUNT,
      SWDT_OFF_STATUS, SWDT_OFF_IRQ_EN, SWDT_OFF_IRQ_CLR, SWDT_OFF_BOOT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign wr_ctrl = wr_acc && (paddr == SWDT_OFF_CTRL);
  assign wr_timeout = wr_acc && (paddr == SWDT_OFF_TIMEOUT);
  // a kick needs the key so a stray write cannot keep a hung system alive
  assign wr_kick = wr_acc && (paddr == SWDT_OFF_KICK) && (pwdata == SWDT_KICK_KEY);
  assign wr_clr = wr_acc && (paddr == SWDT_OFF_IRQ_CLR);
  assign wr_en = wr_acc && (paddr == SWDT_OFF_IRQ_EN);

  // ----------------------------------------------------------------------
  // boot supervision
  // ----------------------------------------------------------------------
  // strap capture
  // the arm window is a single cycle, so a later stop cannot re-arm the boot timeout
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      boot_ff <= SWDT_BOOT_NONE;
      boot_done_ff <= 1'b0;
      boot_pend_ff <= 1'b0;
    end else begin
      boot_pend_ff <= !boot_done_ff;
      if (!boot_done_ff) begin
        boot_ff <= boot_sel;
        boot_done_ff <= 1'b1;
      end
    end
  end

  always_comb begin
    case (boot_ff)
      SWDT_BOOT_30: boot_to = SWDT_BOOT_30_S;
      SWDT_BOOT_60: boot_to = SWDT_BOOT_60_S;
      SWDT_BOOT_90: boot_to = SWDT_BOOT_90_S;
      default: boot_to = SWDT_TIMEOUT_RST;
    endcase
  end

  // arms one cycle after the strap is caught
  assign boot_arm = boot_pend_ff && (state_ff == SWDT_ST_IDLE) && (ctrl_ff == SWDT_CTRL_OFF)
    && !wr_ctrl && (boot_ff != SWDT_BOOT_NONE) && (timeout_ff == SWDT_TIMEOUT_RST)
    && (count_ff == '0) && (status_ff == '0);

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_ff <= SWDT_CTRL_OFF;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[1:0];
    end else if (boot_arm) begin
      ctrl_ff <= SWDT_CTRL_ON;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      timeout_ff <= SWDT_TIMEOUT_RST;
    end else if (wr_timeout) begin
      timeout_ff <= pwdata[7:0];
    end else if (boot_arm) begin
      timeout_ff <= boot_to;
    end
  end

  // ----------------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------------
  // start or retrigger reloads
  assign reload = (wr_ctrl && (pwdata[1:0] == SWDT_CTRL_ON) && (state_ff != SWDT_ST_RUN))
    || (wr_kick && (state_ff == SWDT_ST_RUN)) || boot_arm;

  swdt_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .restart(reload),
    .tick(tick)
  );

  // a timeout of zero is treated as one second
  assign expire = (state_ff == SWDT_ST_RUN) && tick && (count_ff <= 8'd1) && !reload;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SWDT_ST_IDLE: if (reload) nxt_state = SWDT_ST_RUN;
      SWDT_ST_RUN: begin
        if (wr_ctrl && (pwdata[1:0] == SWDT_CTRL_OFF)) begin
          nxt_state = SWDT_ST_IDLE;
        end else if (expire) begin
          nxt_state = SWDT_ST_FIRED;
        end
      end
      SWDT_ST_FIRED: if (wr_ctrl && (pwdata[1:0] == SWDT_CTRL_OFF)) nxt_state = SWDT_ST_IDLE;
      default: nxt_state = SWDT_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_ff <= SWDT_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count_ff <= '0;
    end else if (reload) begin
      count_ff <= boot_arm ? boot_to : timeout_ff;
    end else if ((state_ff == SWDT_ST_RUN) && tick && (count_ff != '0)) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // expiry response
  // ----------------------------------------------------------------------
  // jumper-selected response, held until software disables
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rst_req_ff <= 1'b0;
      nmi_req_ff <= 1'b0;
    end else if (nxt_state == SWDT_ST_FIRED) begin
      rst_req_ff <= !resp_sel;
      nmi_req_ff <= resp_sel;
    end else begin
      rst_req_ff <= 1'b0;
      nmi_req_ff <= 1'b0;
    end
  end

  assign sys_reset_req = rst_req_ff;
  assign nmi_req = nmi_req_ff;

  // ----------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------
  // set wins over clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      status_ff <= '0;
      irq_en_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~(wr_clr ? pwdata[SWDT_EV_W-1:0] : '0))
        | {wr_kick && (state_ff == SWDT_ST_RUN), expire};
      if (wr_en) irq_en_ff <= pwdata[SWDT_EV_W-1:0];
    end
  end

  assign irq = |(status_ff & irq_en_ff);

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      prdata_ff <= '0;
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= psel && !penable && !addr_ok;
      prdata_ff <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          SWDT_OFF_CTRL: prdata_ff <= {30'h0, ctrl_ff};
          SWDT_OFF_TIMEOUT: prdata_ff <= {24'h0, timeout_ff};
          SWDT_OFF_COUNT: prdata_ff <= {24'h0, count_ff};
          SWDT_OFF_STATUS: prdata_ff <= {22'h0, state_ff, 6'h0, status_ff};
          SWDT_OFF_IRQ_EN: prdata_ff <= {30'h0, irq_en_ff};
          SWDT_OFF_BOOT: prdata_ff <= {30'h0, boot_ff};
          default: prdata_ff <= '0;
        endcase
      end
    end
  end

  assign prdata = rd_acc ? prdata_ff : '0;
  assign pslverr = psel && penable && pslverr_ff;

endmodule

//--- verif/swdt_top_checker.sv
/*
  swdt_top_checker: port-level assertions for swdt_top.
  Assumes it is bound into swdt_top and that there is one clock domain.
*/
`timescale 1ns/100ps
module swdt_top_checker
  import swdt_pkg::*;
#(
  parameter int unsigned TICK_CYC = SWDT_TICK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // strap and response
  input wire logic resp_sel,
  input wire logic sys_reset_req,
  input wire logic nmi_req
);
  // ----------------------------------------------------------------------
  // port relations
  // ----------------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic acc;
  logic fire;
  logic stop_w;
  assign acc = psel && penable;
  assign fire = sys_reset_req || nmi_req;
  assign stop_w = acc && pwrite && paddr == SWDT_OFF_CTRL && pwdata[1:0] == SWDT_CTRL_OFF;
  sequence s_ctrl(v);
    (psel && !penable && pwrite && paddr == SWDT_OFF_CTRL && pwdata[1:0] == v)
    ##1 (acc && pwrite && paddr == SWDT_OFF_CTRL && pwdata[1:0] == v);
  endsequence
  AST_PREADY: assert property (pready) else $error("pready low");
  AST_SLVERR: assert property (acc && paddr > 8'h1c |-> pslverr) else $error("no slverr");
  AST_SLVOK: assert property (acc && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("slverr on mapped");
  AST_RDZERO: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero");
  AST_STOP: assert property (s_ctrl(SWDT_CTRL_OFF) |=> !fire) else $error("stop kept response");
  AST_START: assert property (s_ctrl(SWDT_CTRL_ON) ##0 !fire |=> !fire [*8])
    else $error("early expiry");
  AST_HOLD: assert property (fire && !stop_w |=> $stable({sys_reset_req, nmi_req}))
    else $error("response dropped");
  AST_EXCL: assert property (!(sys_reset_req && nmi_req)) else $error("both responses");
  AST_SEL: assert property ($rose(fire) |-> nmi_req == resp_sel) else $error("wrong response");
endmodule

bind swdt_top swdt_top_checker #(.TICK_CYC(TICK_CYC)) swdt_top_checker_inst (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .resp_sel(resp_sel), .sys_reset_req(sys_reset_req), .nmi_req(nmi_req)
);

//--- verif/swdt_top_test.sv
/*
  swdt_top_test: self-checking bench for swdt_top over APB.
  Assumes a shortened one-second tick so expiry fits in a short run.
*/
`timescale 1ns/100ps
module swdt_top_test;
  import swdt_pkg::*;
  localparam int unsigned TC = 10;
  logic sys_clk = 0;
  logic nrst = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic resp_sel = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] boot_sel = SWDT_BOOT_NONE;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] seed = 32'd84;
  logic [31:0] t;
  logic pready;
  logic pslverr;
  logic err;
  logic sys_reset_req;
  logic nmi_req;
  logic irq;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  swdt_top #(.TICK_CYC(TC)) swdt_top_inst (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_sel(boot_sel), .resp_sel(resp_sel), .sys_reset_req(sys_reset_req),
    .nmi_req(nmi_req), .irq(irq)
  );

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // no boot code leaves the timeout at its reset value
  function automatic logic [31:0] boot_s(int c);
    return c == 1 ? SWDT_BOOT_30_S : c == 2 ? SWDT_BOOT_60_S : c == 3 ? SWDT_BOOT_90_S :
      SWDT_TIMEOUT_RST;
  endfunction

  task end_sim;
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task do_reset(input logic [1:0] b);
    nrst <= 1'b0;
    boot_sel <= b;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask

  task wait_fire(input int lo, input int hi);
    n = 0;
    while (sys_reset_req !== 1'b1 && nmi_req !== 1'b1 && n <= hi) begin
      @(posedge sys_clk);
      n++;
    end
    chk("fire time", 1, 32'(n >= lo && n <= hi));
  endtask

  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end

  initial begin
    // every boot code, expiry on the armed timeout, or no expiry for the none code
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      apb(0, SWDT_OFF_BOOT, 0);
      chk("boot", c, rd & 32'h3);
      apb(0, SWDT_OFF_STATUS, 0);
      chk("state", 32'(c != 0), 32'(rd[9:8]));
      apb(0, SWDT_OFF_TIMEOUT, 0);
      chk("timeout", boot_s(c), rd);
      if (c != 0) begin
        apb(0, SWDT_OFF_COUNT, 0);
        chk("boot count", boot_s(c), rd);
        wait_fire(boot_s(c) * TC - 20, boot_s(c) * TC + 2);
        chk("reset req", 1, 32'(sys_reset_req));
      end else begin
        repeat (50) @(posedge sys_clk);
        chk("idle", 0, 32'(sys_reset_req | nmi_req));
      end
    end
    apb(1, 8'h20, 32'hffff_ffff);
    chk("slverr wr", 1, 32'(err));
    apb(0, 8'h20, 0);
    chk("slverr rd", 1, 32'(err));
    chk("unmapped rd", 0, rd);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      t = i == 0 ? 1 : i == 1 ? 255 : 32'(seed[3:0]) + 2;
      // a zero control value stops and drops the response
      apb(1, SWDT_OFF_CTRL, 32'(SWDT_CTRL_OFF));
      resp_sel <= seed[8];
      apb(1, SWDT_OFF_IRQ_CLR, 32'h3);
      // the clear lands at the access edge, so look one edge later
      @(posedge sys_clk);
      chk("stopped", 0, 32'(sys_reset_req | nmi_req));
      chk("irq clr", 0, 32'(irq));
      apb(1, SWDT_OFF_IRQ_EN, 32'(i[0]));
      apb(1, SWDT_OFF_TIMEOUT, t);
      apb(0, SWDT_OFF_TIMEOUT, 0);
      chk("timeout", t, rd);
      if (i == 0) begin
        apb(1, SWDT_OFF_CTRL, 32'h2);
        apb(0, SWDT_OFF_STATUS, 0);
        chk("bad ctrl", 0, 32'(rd[9:8]));
      end
      apb(1, SWDT_OFF_CTRL, 32'(SWDT_CTRL_ON));
      apb(0, SWDT_OFF_COUNT, 0);
      chk("count", t, rd);
      // a retrigger before expiry reloads the full timeout
      if (t > 3) begin
        repeat ((t - 2) * TC) @(posedge sys_clk);
        apb(1, SWDT_OFF_KICK, SWDT_KICK_KEY);
        wait_fire((t - 1) * TC - 2, t * TC + 2);
      end else begin
        wait_fire(t * TC - 6, t * TC + 2);
      end
      chk("resp", {resp_sel, ~resp_sel}, {nmi_req, sys_reset_req});
      chk("irq", 32'(i[0]), 32'(irq));
      apb(0, SWDT_OFF_STATUS, 0);
      chk("status", {22'h0, 2'h3, 6'h0, t > 3, 1'b1}, rd & 32'h303);
    end
    end_sim;
  end
endmodule
